// ==== core/dtc_channel.v ====
// One DMA channel: trigger, pacing, descriptor count and register slave
//
// Notes on behaviour
// - No data moves before a trigger
// - Immediate start clear: wait for hardware/software trigger
// - Writing 1 sets trigger; 0 leaves it
// - Immediate start on config write triggers at once
// - Pacing enabled: transfer only on peripheral request
// - Pacing disabled: transfers back to back
// - Auto clear drops trigger when descriptor exhausted
// - Count is transfers minus one, counts down
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "dtc_consts.vh"
module dtc_channel (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Register bus
  input wire [`DTC_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Pins from the peripheral
  input wire hw_trigger_pin,
  input wire periph_request_pin,
  // Data towards the sink
  output reg [`DTC_DATA_W-1:0] dst_data,
  output reg dst_valid,
  input wire dst_ready,
  // Status
  output reg trigger_pending,
  output reg channel_busy
);

  // Channel states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  // State, settings and descriptor
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] chan_cfg_q;
  reg auto_clr_q;
  reg imm_start_q;
  reg [`DTC_COUNT_W-1:0] count_q;
  reg desc_valid_q;

  // Pin synchroniser and edge memory
  reg hw_prev_q;
  reg [1:0] pin_filt_q;
  wire [1:0] pin_raw;
  wire [1:0] pin_s2;
  wire [1:0] pin_s3;

  // Register bus decode
  wire bus_req;
  wire wr_take;
  wire sel_cfg;
  wire sel_state;
  wire sel_xcfg;
  wire sel_soft;
  wire sel_data;

  // FIFO side
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [`DTC_DATA_W-1:0] fifo_out_data;
  wire fifo_push;

  // Settings fields
  wire pace_en;
  wire hw_en;
  wire trigger_pending_pol;
  wire trigger_pending_level;
  wire burst;

  // Trigger sources
  wire hw_hit;
  wire soft_hit;
  wire imm_hit;
  wire trigger_pending_set;

  // Transfer control
  wire slot_free;
  wire pace_ok;
  wire xfer_go;
  wire last_xfer;
  wire trigger_pending_clr;

  // Address decode, used for every register
  function sel;
    input [`DTC_ADDR_W-1:0] addr;
    input [`DTC_ADDR_W-1:0] ofs;
    begin
      sel = (addr[`DTC_ADDR_W-1:2] == ofs[`DTC_ADDR_W-1:2]);
    end
  endfunction

  // Active sense of a level after polarity
  function sensed;
    input lvl;
    input pol;
    begin
      sensed = pol ? lvl : ~lvl;
    end
  endfunction

  // Hardware trigger decision: gated, then level or edge after polarity
  function hw_fire;
    input en;
    input level_mode;
    input pol;
    input cur;
    input prev;
    begin
      if (!en) begin
        hw_fire = 1'b0;
      end else if (level_mode) begin
        hw_fire = sensed(cur, pol);
      end else begin
        hw_fire = sensed(cur, pol) & ~sensed(prev, pol);
      end
    end
  endfunction

  // Pins from outside pass three flops; change taken once s2 and s3 agree
  assign pin_raw = {hw_trigger_pin, periph_request_pin};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      always @(posedge core_clk) begin
        if (rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      assign pin_s2[gi] = s2_q;
      assign pin_s3[gi] = s3_q;
    end
  endgenerate

  // Filtered pin levels
  always @(posedge core_clk) begin
    if (rst) begin
      pin_filt_q <= 2'b00;
    end else begin
      pin_filt_q <= (pin_s2 & pin_s3) | (pin_filt_q & (pin_s2 | pin_s3));
    end
  end

  // Configuration fields
  assign pace_en = chan_cfg_q[`DTC_CFG_PACING_BIT];
  assign hw_en = chan_cfg_q[`DTC_CFG_HW_TRIGGER_PENDING_EN_BIT];
  assign trigger_pending_pol = chan_cfg_q[`DTC_CFG_POLARITY_BIT];
  assign trigger_pending_level = chan_cfg_q[`DTC_CFG_EDGE_LEVEL_BIT];
  assign burst = chan_cfg_q[`DTC_CFG_BURST_BIT];

  // Bus slave handshake: one wait cycle, then the access takes effect
  assign bus_req = avs_read | avs_write;
  assign sel_cfg = sel(avs_address, `DTC_OFS_CHAN_CFG);
  assign sel_state = sel(avs_address, `DTC_OFS_CHAN_STATE);
  assign sel_xcfg = sel(avs_address, `DTC_OFS_XFER_CFG);
  assign sel_soft = sel(avs_address, `DTC_OFS_SOFT_TRIGGER_PENDING_SET);
  assign sel_data = sel(avs_address, `DTC_OFS_DATA_PUSH);
  assign wr_take = avs_write & ~avs_waitrequest;

  // Data words go into the FIFO; a full FIFO holds the bus in wait
  assign fifo_push = wr_take & sel_data;

  // Hardware trigger detect, edge or level with polarity
  assign hw_hit = hw_fire(hw_en, trigger_pending_level, trigger_pending_pol, pin_filt_q[1],
                          hw_prev_q);

  // Software set and immediate start
  assign soft_hit = wr_take & sel_soft & avs_byteenable[0] &
                    avs_writedata[`DTC_SOFT_TRIGGER_PENDING_BIT];
  assign imm_hit = wr_take & sel_xcfg & avs_byteenable[0] &
                   avs_writedata[`DTC_XCFG_IMM_START_BIT];
  assign trigger_pending_set = hw_hit | soft_hit | imm_hit;

  // A transfer needs trigger, descriptor, data, a free slot and pacing
  assign slot_free = ~dst_valid | dst_ready;
  assign pace_ok = ~pace_en | pin_filt_q[0];
  assign xfer_go = state_q[2] & trigger_pending & desc_valid_q &
                   fifo_out_valid & slot_free & pace_ok;
  assign last_xfer = xfer_go & (count_q == `DTC_COUNT_RESET);

  // Clear on exhaustion when auto clear is set, or after each transfer for single hw triggers
  assign trigger_pending_clr = (last_xfer & auto_clr_q) |
                    (xfer_go & hw_en & ~burst);

  dtc_fifo #(
    .WIDTH(`DTC_DATA_W),
    .DEPTH(`DTC_FIFO_DEPTH),
    .PTR_W(`DTC_FIFO_PTR_W)
  ) u_fifo (
    .clk(core_clk),
    .rst(rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(avs_writedata),
    .out_valid(fifo_out_valid),
    .out_ready(xfer_go),
    .out_data(fifo_out_data)
  );

  // Waitrequest drops one cycle after a request, held for a data push while FIFO is full
  always @(posedge core_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_req && avs_waitrequest) begin
      avs_waitrequest <= ~(~(avs_write & sel_data) | fifo_in_ready);
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // Read data captured in the cycle waitrequest falls
  always @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      if (sel_cfg) begin
        avs_readdata <= chan_cfg_q;
      end else if (sel_state) begin
        avs_readdata <= {6'h00, count_q, 13'h0000, trigger_pending,
                         state_q[2], desc_valid_q};
      end else if (sel_xcfg) begin
        avs_readdata <= {6'h00, count_q, 13'h0000, imm_start_q, 1'b0,
                         auto_clr_q};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // Channel configuration register with byte enables
  always @(posedge core_clk) begin
    if (rst) begin
      chan_cfg_q <= `DTC_CFG_RESET;
    end else if (wr_take && sel_cfg && avs_byteenable[0]) begin
      chan_cfg_q <= {24'h000000, avs_writedata[7:0]} & `DTC_CFG_MASK;
    end
  end

  // Transfer configuration: a write loads a fresh descriptor
  always @(posedge core_clk) begin
    if (rst) begin
      auto_clr_q <= 1'b0;
      imm_start_q <= 1'b0;
      count_q <= `DTC_COUNT_RESET;
      desc_valid_q <= 1'b0;
    end else if (wr_take && sel_xcfg) begin
      if (avs_byteenable[0]) begin
        auto_clr_q <= avs_writedata[`DTC_XCFG_AUTO_CLR_BIT];
        imm_start_q <= avs_writedata[`DTC_XCFG_IMM_START_BIT];
      end
      count_q <= avs_writedata[`DTC_XCFG_COUNT_MSB:`DTC_XCFG_COUNT_LSB];
      desc_valid_q <= 1'b1;
    end else if (last_xfer) begin
      desc_valid_q <= 1'b0;
    end else if (xfer_go) begin
      count_q <= count_q - 1'b1;
    end
  end

  // Trigger flag: a set in the same cycle as a clear wins
  always @(posedge core_clk) begin
    if (rst) begin
      trigger_pending <= 1'b0;
    end else if (trigger_pending_set) begin
      trigger_pending <= 1'b1;
    end else if (trigger_pending_clr) begin
      trigger_pending <= 1'b0;
    end
  end

  // Edge memory holds the pin level, not its active sense, so that a
  // polarity change alone never looks like a trigger edge
  always @(posedge core_clk) begin
    if (rst) begin
      hw_prev_q <= 1'b0;
    end else begin
      hw_prev_q <= pin_filt_q[1];
    end
  end

  // Channel state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (wr_take && sel_xcfg) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (trigger_pending && desc_valid_q) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (last_xfer) begin
          state_d = ST_IDLE;
        end else if (!trigger_pending) begin
          state_d = ST_WAIT;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register and busy output
  always @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      channel_busy <= 1'b0;
    end else begin
      state_q <= state_d;
      channel_busy <= state_d[2];
    end
  end

  // Destination stage holds a word until the sink takes it
  always @(posedge core_clk) begin
    if (rst) begin
      dst_valid <= 1'b0;
      dst_data <= {`DTC_DATA_W{1'b0}};
    end else if (xfer_go) begin
      dst_valid <= 1'b1;
      dst_data <= fifo_out_data;
    end else if (dst_ready) begin
      dst_valid <= 1'b0;
    end
  end

endmodule // dtc_channel

// ==== core/dtc_consts.vh ====
// Register map, field layout and reset values of the DMA trigger control
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

// Register byte offsets on the Avalon-MM slave
`define DTC_ADDR_W 8
`define DTC_OFS_CHAN_CFG 8'h00
`define DTC_OFS_CHAN_STATE 8'h04
`define DTC_OFS_XFER_CFG 8'h08
`define DTC_OFS_SOFT_TRIGGER_PENDING_SET 8'h0c
`define DTC_OFS_DATA_PUSH 8'h10

// Channel configuration fields
`define DTC_CFG_PACING_BIT 0
`define DTC_CFG_HW_TRIGGER_PENDING_EN_BIT 1
`define DTC_CFG_POLARITY_BIT 4
`define DTC_CFG_EDGE_LEVEL_BIT 5
`define DTC_CFG_BURST_BIT 6
`define DTC_CFG_MASK 32'h0000_0073
`define DTC_CFG_RESET 32'h0000_0000

// Transfer configuration fields
`define DTC_XCFG_AUTO_CLR_BIT 0
`define DTC_XCFG_IMM_START_BIT 2
`define DTC_XCFG_COUNT_LSB 16
`define DTC_XCFG_COUNT_MSB 25
`define DTC_COUNT_W 10
`define DTC_COUNT_RESET 10'h000

// Channel state fields
`define DTC_STATE_VALID_BIT 0
`define DTC_STATE_BUSY_BIT 1
`define DTC_STATE_TRIGGER_PENDING_BIT 2

// Channel bit in the soft trigger set register
`define DTC_SOFT_TRIGGER_PENDING_BIT 0

// Data path
`define DTC_DATA_W 32
`define DTC_FIFO_DEPTH 16
`define DTC_FIFO_PTR_W 4

`endif

// ==== core/dtc_fifo.v ====
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module dtc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter PTR_W = 4
) (
  input wire clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_q;
  reg [PTR_W-1:0] rd_ptr_q;
  reg [PTR_W:0] fill_q;
  wire push;
  wire pop;

  // Honest full and empty from the fill count
  assign in_ready = (fill_q != DEPTH[PTR_W:0]);
  assign out_valid = (fill_q != {(PTR_W+1){1'b0}});
  assign out_data = mem[rd_ptr_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage array, written only on an accepted push
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and fill level
  always @(posedge clk) begin
    if (rst) begin
      wr_ptr_q <= {PTR_W{1'b0}};
      rd_ptr_q <= {PTR_W{1'b0}};
      fill_q <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        fill_q <= fill_q + 1'b1;
      end else if (pop && !push) begin
        fill_q <= fill_q - 1'b1;
      end
    end
  end

endmodule // dtc_fifo

// ==== verification/dtc_channel_sva.sv ====
// Port checks for the DMA channel
`timescale 1ns/1ps
`include "dtc_consts.vh"
module dtc_chan_sva (
  input logic core_clk,
  input logic rst,
  input logic [`DTC_ADDR_W-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  input logic [31:0] avs_readdata,
  input logic avs_waitrequest,
  input logic hw_trigger_pin,
  input logic periph_request_pin,
  input logic [`DTC_DATA_W-1:0] dst_data,
  input logic dst_valid,
  input logic dst_ready,
  input logic trigger_pending,
  input logic channel_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [6:0] cfg_q;
  logic clr_q;
  wire wr = avs_write && !avs_waitrequest;
  wire [7:0] a = avs_address;
  wire [31:0] wd = avs_writedata;
  // Shadow of the channel settings and the auto clear flag
  always @(posedge core_clk) begin
    if (rst) begin
      cfg_q <= 7'h00;
      clr_q <= 1'b0;
    end else if (wr && a == `DTC_OFS_CHAN_CFG) begin
      cfg_q <= wd[6:0];
    end else if (wr && a == `DTC_OFS_XFER_CFG) begin
      clr_q <= wd[0];
    end
  end
  chk_run_trigger_pending:
    assert property ($rose(channel_busy) |-> $past(trigger_pending))
    else $error("run without trigger");
  chk_soft_set:
    assert property (wr && a == 8'h0c && wd[0] |=> trigger_pending)
    else $error("soft set lost");
  chk_zero_keep:
    assert property (wr && a == 8'h0c && !wd[0] && trigger_pending
      && !channel_busy |=> trigger_pending) else $error("zero write cleared");
  chk_imm_start:
    assert property (wr && a == 8'h08 && wd[2] |=> trigger_pending)
    else $error("immediate start lost");
  chk_pace_hold:
    assert property ((cfg_q[0] && !periph_request_pin)[*8] |=>
      !$rose(dst_valid)) else $error("move without request");
  chk_full_speed:
    assert property ($rose(channel_busy) && !cfg_q[0] |-> ##[1:4] dst_valid)
    else $error("full speed stalled");
  chk_auto_clr:
    assert property ($fell(channel_busy) && clr_q |-> ##[0:2]
      !trigger_pending) else $error("trigger not cleared");
  chk_hw_gate:
    assert property ($rose(trigger_pending) && !$past(cfg_q[1]) |->
      $past(wr)) else $error("trigger with hardware off");
  cover property ($rose(dst_valid) && cfg_q[0]);
  cover property ($fell(trigger_pending));
  cover property (dst_valid && !dst_ready);
endmodule // dtc_chan_sva
bind dtc_channel dtc_chan_sva dtc_chan_sva_i (.*);

// ==== verification/dtc_periph_model.sv ====
// Peripheral side: trigger and request pins, stalling data sink
`timescale 1ns/1ps
module dtc_periph_model (
  input logic core_clk,
  input logic trigger_pending_cmd,
  input logic req_cmd,
  input logic slow,
  input logic [31:0] dst_data,
  input logic dst_valid,
  output logic hw_trigger_pin = 1'b0,
  output logic periph_request_pin = 1'b0,
  output logic dst_ready = 1'b0
);
  logic [31:0] got[$];
  // Pins follow the bench; sink takes every other cycle when slow
  always @(posedge core_clk) begin
    if (dst_valid && dst_ready) got.push_back(dst_data);
    hw_trigger_pin <= trigger_pending_cmd;
    periph_request_pin <= req_cmd;
    dst_ready <= !slow || !dst_ready;
  end
endmodule // dtc_periph_model

// ==== verification/tb_top.sv ====
// Bench for the DMA channel: register tasks and trigger scenarios
`timescale 1ns/1ps
`include "dtc_consts.vh"
module tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rv, dst_data;
  logic avs_waitrequest, hw_trigger_pin, periph_request_pin;
  logic dst_valid, dst_ready, trigger_pending, channel_busy;
  logic trigger_pending_cmd = 1'b0;
  logic req_cmd = 1'b0;
  logic slow = 1'b0;
  int n_fail = 0;
  int total_checks = 0;
  always #5 core_clk = ~core_clk;
  dtc_channel dtc_channel_i (
    .core_clk(core_clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .hw_trigger_pin(hw_trigger_pin),
    .periph_request_pin(periph_request_pin),
    .dst_data(dst_data),
    .dst_valid(dst_valid),
    .dst_ready(dst_ready),
    .trigger_pending(trigger_pending),
    .channel_busy(channel_busy)
  );
  dtc_periph_model dtc_periph_model_i (
    .core_clk(core_clk),
    .trigger_pending_cmd(trigger_pending_cmd),
    .req_cmd(req_cmd),
    .slow(slow),
    .dst_data(dst_data),
    .dst_valid(dst_valid),
    .hw_trigger_pin(hw_trigger_pin),
    .periph_request_pin(periph_request_pin),
    .dst_ready(dst_ready)
  );
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge core_clk);
    // No cycle limit here: a hang is caught by the watchdog
    while (avs_waitrequest !== 1'b0) begin
      @(posedge core_clk);
    end
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  // Push n words, then load the descriptor
  task automatic load(input logic [31:0] b, input int n, input logic [31:0] x);
    for (int i = 0; i < n; i++) bus(1'b1, `DTC_OFS_DATA_PUSH, b + i);
    bus(1'b1, `DTC_OFS_XFER_CFG, x);
  endtask
  task automatic cnt(input int e);
    chk("words", 32'(dtc_periph_model_i.got.size()), e);
  endtask
  task automatic word(input int i, input logic [31:0] e);
    chk("word", dtc_periph_model_i.got[i], e);
  endtask
  task automatic wait_n(input int n);
    for (int k = 0; k < 200 && dtc_periph_model_i.got.size() < n; k++)
      @(posedge core_clk);
    idle(20);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    idle(20);
    rst <= 1'b0;
    idle(1);
    bus(1'b0, `DTC_OFS_CHAN_CFG, 32'h0);
    chk("cfg", rv, `DTC_CFG_RESET);
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped", rv, 32'h0);
    load(32'h0000_0a00, 2, 32'h0001_0001);
    idle(20);
    cnt(0);
    bus(1'b0, `DTC_OFS_CHAN_STATE, 32'h0);
    chk("state", rv & 32'h03ff_0006, 32'h0001_0000);
    bus(1'b1, `DTC_OFS_SOFT_TRIGGER_PENDING_SET, 32'hffff_fffe);
    idle(20);
    cnt(0);
    bus(1'b1, `DTC_OFS_SOFT_TRIGGER_PENDING_SET, 32'h1);
    wait_n(2);
    cnt(2);
    word(1, 32'h0000_0a01);
    chk("trigger_pending", trigger_pending, 0);
    // Paced, level trigger active high
    bus(1'b1, `DTC_OFS_CHAN_CFG, 32'h0000_0073);
    load(32'h0000_0b00, 2, 32'h0001_0001);
    idle(20);
    cnt(2);
    trigger_pending_cmd <= 1'b1;
    idle(10);
    trigger_pending_cmd <= 1'b0;
    idle(20);
    chk("trigger_pending", trigger_pending, 1);
    chk("busy", channel_busy, 1);
    cnt(2);
    req_cmd <= 1'b1;
    wait_n(4);
    req_cmd <= 1'b0;
    word(3, 32'h0000_0b01);
    chk("trigger_pending", trigger_pending, 0);
    // Edge trigger active low, one transfer per trigger
    bus(1'b1, `DTC_OFS_CHAN_CFG, 32'h0000_0002);
    load(32'h0000_0c00, 2, 32'h0001_0000);
    idle(20);
    cnt(4);
    for (int i = 5; i < 7; i++) begin
      trigger_pending_cmd <= 1'b1;
      idle(8);
      trigger_pending_cmd <= 1'b0;
      idle(20);
      cnt(i);
      chk("trigger_pending", trigger_pending, 0);
    end
    word(5, 32'h0000_0c01);
    // Immediate start into a stalling sink
    bus(1'b1, `DTC_OFS_CHAN_CFG, 32'h0);
    slow <= 1'b1;
    load(32'h0000_0d00, 3, 32'h0002_0004);
    wait_n(9);
    word(8, 32'h0000_0d02);
    chk("trigger_pending", trigger_pending, 1);
    chk("busy", channel_busy, 0);
    bus(1'b1, `DTC_OFS_SOFT_TRIGGER_PENDING_SET, 32'h0);
    chk("trigger_pending", trigger_pending, 1);
    tally_and_finish;
  end
endmodule // tb_top
